// ==== hdl/dcel_pkg.sv ====
//////////////////////////////////////////////////////////////////////////////
// Purpose: Shared constants and carriers of the dual comparator event logic
// Assumes: Byte addresses on a 32-bit Avalon-MM slave, data in low byte
// Notes:   Configuration byte layout is common to both comparators
//////////////////////////////////////////////////////////////////////////////
package dcel_pkg;
    // Number of comparators
    localparam int NUM_CMP = 2;

    // Register byte offsets
    localparam logic [4:0] OFS_CFG0 = 5'h00;
    localparam logic [4:0] CFG_STRIDE = 5'h04;
    localparam logic [4:0] OFS_APC = 5'h08;
    localparam logic [4:0] OFS_STAT = 5'h0C;
    localparam logic [4:0] OFS_MASK = 5'h10;

    // Configuration register fields
    localparam int CFG_EN = 0;
    localparam int CFG_POS = 1;
    localparam int CFG_NEG = 2;
    localparam int CFG_OUT = 3;
    localparam int CFG_FLAG = 4;
    localparam int CFG_RES = 5;
    localparam int CFG_SETTLED = 6;

    // Auxiliary power control field
    localparam int APC_CMP_OFF = 5;

    // Reset values
    localparam logic [3:0] CFG_RST = 4'h0;
    localparam logic [7:0] APC_RST = 8'h00;
    localparam logic [1:0] MASK_RST = 2'h0;
    localparam logic [31:0] RDATA_RST = 32'h0000_0000;

    // Settling time after enable, and its count at the core clock
    localparam int SETTLE_US = 10;
    localparam int CLK_MHZ = 125;
    localparam int SETTLE_CYC = SETTLE_US * CLK_MHZ;

    // Software view of one comparator's setup
    typedef struct packed {
        logic out_en;   // Route result to its pin
        logic neg_ref;  // Negative input from internal reference
        logic pos_sel;  // Which of two positive input pins
        logic enable;   // Comparator switched on
    } dcel_cfg_s;

    // Controls toward one analog comparator
    typedef struct packed {
        logic power;    // Effective enable
        logic pos_sel;  // Positive input select
        logic neg_ref;  // Negative input select
    } dcel_ana_s;
endpackage : dcel_pkg

// ==== hdl/dcel_top.sv ====
//////////////////////////////////////////////////////////////////////////////
// Purpose: Control, change flags and interrupt of two analog comparators
// Assumes: Raw results arrive asynchronously; power mode from same clock
// Notes:   Registers on Avalon-MM, one wait state per access
//////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - Result one when positive above negative input
// - Positive from two pins, negative pin or reference
// - Result readable and routable to a pin
// - Reference serves when single input pin used
// - Change flag sits in own configuration register
// - Any result change sets the change flag
// - Flag polled, or interrupts when enabled
// - One shared interrupt, flags identify source
// - Disabled comparator result forced high
// - Forced rise counts as change, sets flag
// - Runs in idle, off in total power-down
// - Enabled change raises interrupt and wakes
// - Power control bit five disables comparators
module dcel_top
    import dcel_pkg::*;
#(
    parameter int SETTLE_CYCLES = SETTLE_CYC
)(
    input wire logic clk,                              // Core clock
    input wire logic reset,                            // Sync reset, high
    input wire logic ce,                               // Clock enable
    input wire logic [4:0] avs_address,                // Byte address
    input wire logic avs_read,                         // Read request
    input wire logic avs_write,                        // Write request
    input wire logic [31:0] avs_writedata,             // Write data
    input wire logic [3:0] avs_byteenable,             // Byte lanes
    output logic [31:0] avs_readdata,                  // Read data
    output logic avs_waitrequest,                      // Stall
    input wire logic [NUM_CMP-1:0] raw_result,         // Analog outputs
    input wire logic total_powerdown,                  // Deep sleep mode
    output dcel_ana_s [NUM_CMP-1:0] ana_ctrl,          // Analog controls
    output logic ref_enable,                           // Reference on
    output logic [NUM_CMP-1:0] comparator_result_out,  // Result pins
    output logic irq                                   // Interrupt, wake
);

    //////////////////////////////////////////////////////////////////////////
    // Register state
    dcel_cfg_s cfg [NUM_CMP];
    logic [7:0] aux_power_control;
    logic [NUM_CMP-1:0] int_mask;
    logic [NUM_CMP-1:0] comparator_change_flag;
    logic [NUM_CMP-1:0] result_q;
    logic [NUM_CMP-1:0] prev_q;
    logic [NUM_CMP-1:0] settled;
    logic [NUM_CMP-1:0] eff_en;
    logic [NUM_CMP-1:0] use_ref;
    logic [NUM_CMP-1:0] changed;
    logic wr_take;
    logic [7:0] wbyte;
    logic [31:0] next_readdata;

    // Write lands only at the edge after the wait state, where waitrequest is sampled low
    assign wr_take = ce & avs_write & ~avs_waitrequest & avs_byteenable[0];
    assign wbyte = avs_writedata[7:0];

    //////////////////////////////////////////////////////////////////////////
    // Bus handshake: exactly one wait state on every access
    always_ff @(posedge clk) begin
        if (reset) begin
            avs_waitrequest <= 1'b1;
        end else if (ce) begin
            avs_waitrequest <= ~((avs_read | avs_write) & avs_waitrequest);
        end
    end

    // Read data captured in the wait state, stable at the sampling edge
    always_ff @(posedge clk) begin
        if (reset) begin
            avs_readdata <= RDATA_RST;
        end else if (ce && avs_read && avs_waitrequest) begin
            avs_readdata <= next_readdata;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Global controls
    always_ff @(posedge clk) begin
        if (reset) begin
            aux_power_control <= APC_RST;
        end else if (wr_take && avs_address == OFS_APC) begin
            aux_power_control <= wbyte;
        end
    end

    // Mask doubles as the per-comparator interrupt enable
    always_ff @(posedge clk) begin
        if (reset) begin
            int_mask <= MASK_RST;
        end else if (wr_take && avs_address == OFS_MASK) begin
            int_mask <= wbyte[NUM_CMP-1:0];
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Per-comparator logic
    for (genvar i = 0; i < NUM_CMP; i++) begin : g_cmp
        localparam logic [4:0] MY_OFS = OFS_CFG0 + 5'(i) * CFG_STRIDE;
        localparam int CW = $clog2(SETTLE_CYCLES + 1);
        logic s1, s2, s3, filt;
        logic clr;
        logic [CW-1:0] settle_cnt;

        // Off by enable bit clear, disable bit or total power-down, never by idle modes
        assign eff_en[i] = cfg[i].enable & ~aux_power_control[APC_CMP_OFF]
                           & ~total_powerdown;
        assign use_ref[i] = eff_en[i] & cfg[i].neg_ref;
        assign changed[i] = result_q[i] ^ prev_q[i];

        // Software clears by zero in config or one in status
        assign clr = wr_take & (((avs_address == MY_OFS) & ~wbyte[CFG_FLAG])
                     | ((avs_address == OFS_STAT) & wbyte[i]));

        // Setup written from the config byte
        always_ff @(posedge clk) begin
            if (reset) begin
                cfg[i] <= dcel_cfg_s'(CFG_RST);
            end else if (wr_take && avs_address == MY_OFS) begin
                cfg[i] <= dcel_cfg_s'(wbyte[CFG_OUT:CFG_EN]);
            end
        end

        // Three-stage sync; value moves only when stages two and three agree
        always_ff @(posedge clk) begin
            if (reset) begin
                s1 <= 1'b1;
                s2 <= 1'b1;
                s3 <= 1'b1;
                filt <= 1'b1;
            end else if (ce) begin
                s1 <= raw_result[i];
                s2 <= s1;
                s3 <= s2;
                if (s2 == s3) begin
                    filt <= s3;
                end
            end
        end

        // Result follows analog decision while on, held high while off
        always_ff @(posedge clk) begin
            if (reset) begin
                result_q[i] <= 1'b1;
                prev_q[i] <= 1'b1;
            end else if (ce) begin
                result_q[i] <= eff_en[i] ? filt : 1'b1;
                prev_q[i] <= result_q[i];
            end
        end

        // Sticky flag; forced rise on disable counts as a change too
        always_ff @(posedge clk) begin
            if (reset) begin
                comparator_change_flag[i] <= 1'b0;
            end else if (ce) begin
                if (changed[i]) begin
                    comparator_change_flag[i] <= 1'b1;
                end else if (clr) begin
                    comparator_change_flag[i] <= 1'b0;
                end
            end
        end

        // Settling timer so software can poll instead of timing 10 us
        always_ff @(posedge clk) begin
            if (reset) begin
                settle_cnt <= '0;
                settled[i] <= 1'b0;
            end else if (ce) begin
                if (!eff_en[i]) begin
                    settle_cnt <= '0;
                    settled[i] <= 1'b0;
                end else if (settle_cnt == CW'(SETTLE_CYCLES - 1)) begin
                    settled[i] <= 1'b1;
                end else begin
                    settle_cnt <= settle_cnt + 1'b1;
                end
            end
        end

        // Analog side controls and pin routing, registered
        always_ff @(posedge clk) begin
            if (reset) begin
                ana_ctrl[i] <= '0;
                comparator_result_out[i] <= 1'b1;
            end else if (ce) begin
                ana_ctrl[i].power <= eff_en[i];
                ana_ctrl[i].pos_sel <= cfg[i].pos_sel;
                ana_ctrl[i].neg_ref <= cfg[i].neg_ref;
                comparator_result_out[i] <= result_q[i] | ~cfg[i].out_en;
            end
        end

        a_forced_high: assert property (@(posedge clk) disable iff (reset)
            ce && !eff_en[i] |=> result_q[i])
            else $error("disabled comparator result not high");

        a_flag_sets: assert property (@(posedge clk) disable iff (reset)
            ce && (result_q[i] != prev_q[i]) |=> comparator_change_flag[i])
            else $error("change did not set flag");

        a_set_wins: assert property (@(posedge clk) disable iff (reset)
            ce && changed[i] && clr |=> comparator_change_flag[i])
            else $error("clear beat a simultaneous set");

        a_flag_sticky: assert property (@(posedge clk) disable iff (reset)
            comparator_change_flag[i] && !(ce && clr) |=> comparator_change_flag[i])
            else $error("flag dropped without a clear");

        a_disable_chain: assert property (@(posedge clk) disable iff (reset)
            ce && !result_q[i] && !eff_en[i] ##1 ce [*2] |=> comparator_change_flag[i])
            else $error("forced rise did not flag");

        a_pin_route: assert property (@(posedge clk) disable iff (reset)
            ce |=> comparator_result_out[i] == $past(result_q[i] | ~cfg[i].out_en))
            else $error("result pin wrong");

        a_tpd_off: assert property (@(posedge clk) disable iff (reset)
            ce && total_powerdown |=> !ana_ctrl[i].power)
            else $error("comparator powered in total power-down");

        a_apc_off: assert property (@(posedge clk) disable iff (reset)
            ce && aux_power_control[APC_CMP_OFF] |=> result_q[i])
            else $error("disable bit did not force result high");

        // Freeze, clear and settle timer checks
        a_ce_freeze: assert property (@(posedge clk) disable iff (reset)
            !ce |=> $stable(comparator_change_flag[i]))
            else $error("flag moved while clock enable low");

        a_flag_clears: assert property (@(posedge clk) disable iff (reset)
            ce && clr && !changed[i] |=> !comparator_change_flag[i])
            else $error("software clear did not drop flag");

        a_settle_reset: assert property (@(posedge clk) disable iff (reset)
            ce && !eff_en[i] |=> !settled[i])
            else $error("settled bit high while comparator off");
    end

    //////////////////////////////////////////////////////////////////////////
    // Shared interrupt; level also serves as wake request from sleep
    always_ff @(posedge clk) begin
        if (reset) begin
            irq <= 1'b0;
            ref_enable <= 1'b0;
        end else if (ce) begin
            irq <= |(comparator_change_flag & int_mask);
            ref_enable <= |use_ref;
        end
    end

    // Read view; flags appear in config and in the shared status word
    always_comb begin
        next_readdata = '0;
        for (int k = 0; k < NUM_CMP; k++) begin
            if (avs_address == OFS_CFG0 + 5'(k) * CFG_STRIDE) begin
                next_readdata[CFG_OUT:CFG_EN] = cfg[k];
                next_readdata[CFG_FLAG] = comparator_change_flag[k];
                next_readdata[CFG_RES] = result_q[k];
                next_readdata[CFG_SETTLED] = settled[k];
            end
        end
        case (avs_address)
            OFS_APC: next_readdata[7:0] = aux_power_control;
            OFS_STAT: next_readdata[NUM_CMP-1:0] = comparator_change_flag;
            OFS_MASK: next_readdata[NUM_CMP-1:0] = int_mask;
            default: ;
        endcase
    end

    //////////////////////////////////////////////////////////////////////////
    // Checks on shared outputs and the mask register
    a_irq_level: assert property (@(posedge clk) disable iff (reset)
        ce |=> irq == $past(|(comparator_change_flag & int_mask)))
        else $error("interrupt does not follow masked flags");

    a_ref_enable: assert property (@(posedge clk) disable iff (reset)
        ce |=> ref_enable == $past(|use_ref))
        else $error("reference enable wrong");

    a_one_wait: assert property (@(posedge clk) disable iff (reset)
        ce && (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("access not answered after one wait state");

    a_read_hold: assert property (@(posedge clk) disable iff (reset)
        !avs_read |=> $stable(avs_readdata))
        else $error("read data changed without a read");

    a_mask_write: assert property (@(posedge clk) disable iff (reset)
        wr_take && avs_address == OFS_MASK |=> int_mask == $past(wbyte[NUM_CMP-1:0]))
        else $error("mask write did not land");

endmodule : dcel_top

// ==== tb/dcel_ana_model.sv ====
//////////////////////////////////////////////////////////////////////////////
// Purpose: Behavioural pair of analog comparators behind the event logic
// Assumes: Voltages in millivolts, reference fixed at its nominal value
// Notes:   An unpowered output toggles every cycle, so no stale level is seen
//////////////////////////////////////////////////////////////////////////////
module dcel_ana_model
    import dcel_pkg::*;
#(
    parameter int REF_MV = 1230
)(
    input wire logic clk,                              // Core clock
    input wire dcel_ana_s [NUM_CMP-1:0] ana_ctrl,      // Controls
    input wire logic ref_enable,                       // Reference on
    input wire logic [NUM_CMP-1:0][1:0][11:0] pos_mv,  // Positive pins
    input wire logic [NUM_CMP-1:0][11:0] neg_mv,       // Negative pins
    output logic [NUM_CMP-1:0] raw_result              // Decisions
);
    timeunit 1ns;
    timeprecision 1ps;
    logic tog = 1'b0;
    // Dead-output pattern
    always @(posedge clk) tog <= ~tog;
    // Decision per comparator; reference useless while its generator is off
    always_comb begin
        for (int i = 0; i < NUM_CMP; i++) begin
            if (!ana_ctrl[i].power) begin
                raw_result[i] = tog;
            end else if (ana_ctrl[i].neg_ref) begin
                raw_result[i] = ref_enable ? (pos_mv[i][ana_ctrl[i].pos_sel] > 12'(REF_MV)) : tog;
            end else begin
                raw_result[i] = pos_mv[i][ana_ctrl[i].pos_sel] > neg_mv[i];
            end
        end
    end
endmodule : dcel_ana_model

// ==== tb/tb.sv ====
//////////////////////////////////////////////////////////////////////////////
// Purpose: Self-checking bench of the dual comparator event logic
// Assumes: Short settle parameter, one wait state per bus access
// Notes:   Voltages and setups drawn from a fixed LFSR seed
//////////////////////////////////////////////////////////////////////////////
module tb;
    import dcel_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, reset, ce, avs_read, avs_write, avs_waitrequest, ref_enable, irq, tpd, apc5;
    logic [3:0] be;
    logic [4:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata, seed, rd;
    logic [1:0] raw, res_out, mask, exp_flag, prev;
    logic [3:0] cfg [2];
    dcel_ana_s [NUM_CMP-1:0] ana;
    logic [NUM_CMP-1:0][1:0][11:0] pos_mv;
    logic [NUM_CMP-1:0][11:0] neg_mv;
    int err_total, tests_run;

    dcel_top #(.SETTLE_CYCLES(8)) u_dut (.clk(clk), .reset(reset), .ce(ce),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(be), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .raw_result(raw), .total_powerdown(tpd),
        .ana_ctrl(ana), .ref_enable(ref_enable), .comparator_result_out(res_out), .irq(irq));
    dcel_ana_model u_ana (.clk(clk), .ana_ctrl(ana), .ref_enable(ref_enable),
        .pos_mv(pos_mv), .neg_mv(neg_mv), .raw_result(raw));

    //////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    function automatic logic pw(input int i);
        return cfg[i][0] & ~apc5 & ~tpd;
    endfunction : pw
    // Powered decision, else forced high
    function automatic logic exp_res(input int i);
        logic [11:0] n;
        n = cfg[i][2] ? 12'h4CE : neg_mv[i];
        return pw(i) ? (pos_mv[i][cfg[i][1]] > n) : 1'b1;
    endfunction : exp_res
    task automatic chk_reg(input string nm, input logic [7:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== {24'h000000, e}) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask : chk_reg
    task automatic chk_pin(input string nm, input logic [5:0] e, input logic [5:0] g);
        tests_run++;
        if (g !== e) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask : chk_pin
    // One access, held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [4:0] a, input logic [7:0] d);
        avs_address <= a;
        avs_writedata <= {24'h000000, d};
        avs_write <= wr;
        avs_read <= ~wr;
        @(posedge clk);
        while (avs_waitrequest !== 1'b0) begin
            @(posedge clk);
        end
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge clk);
    endtask : bus
    // Let the sync chain settle, then check every visible result
    task automatic settle;
        logic [5:0] ea;
        logic [1:0] eo;
        repeat (12) @(posedge clk);
        for (int i = 0; i < 2; i++) begin
            if (exp_res(i) != prev[i]) exp_flag[i] = 1'b1;
            prev[i] = exp_res(i);
            eo[i] = cfg[i][3] ? prev[i] : 1'b1;
            ea[i*3 +: 3] = {pw(i), cfg[i][1], cfg[i][2]};
            bus(1'b0, 5'(OFS_CFG0 + CFG_STRIDE * i), 8'h00);
            chk_reg("config", {1'b0, pw(i), prev[i], exp_flag[i], cfg[i]}, rd);
        end
        bus(1'b0, OFS_STAT, 8'h00);
        chk_reg("status", {6'h00, exp_flag}, rd);
        chk_pin("result_out", {4'h0, eo}, {4'h0, res_out});
        chk_pin("ana_ctrl", ea, ana);
        chk_pin("ref_enable", {5'h00, (pw(0) & cfg[0][2]) | (pw(1) & cfg[1][2])}, {5'h00, ref_enable});
        chk_pin("irq", {5'h00, |(exp_flag & mask)}, {5'h00, irq});
    endtask : settle
    // Outputs are unreliable just after power-up, so wait and clear the flags
    task automatic rearm(input logic via_cfg);
        repeat (12) @(posedge clk);
        if (via_cfg) begin
            for (int i = 0; i < 2; i++) bus(1'b1, 5'(OFS_CFG0 + CFG_STRIDE * i), {4'h0, cfg[i]});
        end else begin
            bus(1'b1, OFS_STAT, 8'h03);
        end
        exp_flag = 2'b00;
        for (int i = 0; i < 2; i++) prev[i] = exp_res(i);
    endtask : rearm
    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : stop_test

    //////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // Watchdog well beyond the expected run of about 1900 cycles
    initial begin
        repeat (20000) @(posedge clk);
        err_total++;
        $display("ERROR watchdog expected done seen timeout");
        stop_test;
    end
    initial begin
        {reset, ce, avs_read, avs_write, tpd, apc5} = 6'h30;
        be = 4'hF;
        {avs_address, avs_writedata, mask, exp_flag, prev} = {37'h0, 6'h3};
        {cfg[0], cfg[1], pos_mv, neg_mv} = '0;
        seed = 32'h46A53C3B;
        err_total = 0;
        tests_run = 0;
        repeat (8) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        settle;
        bus(1'b0, OFS_APC, 8'h00);
        chk_reg("aux_power_control", APC_RST, rd);
        bus(1'b0, 5'h14, 8'h00);
        chk_reg("unmapped", 8'h00, rd);
        // Random setups and voltages, flags cleared two ways
        for (int k = 0; k < 24; k++) begin
            seed = lfsr(seed);
            for (int i = 0; i < 2; i++) begin
                cfg[i] = {seed[i*3 +: 3], 1'b1};
                bus(1'b1, 5'(OFS_CFG0 + CFG_STRIDE * i), {4'h1, cfg[i]});
            end
            rearm(k[0]);
            mask = seed[7:6];
            bus(1'b1, OFS_MASK, {6'h00, mask});
            settle;
            for (int j = 0; j < 6; j++) begin
                seed = lfsr(lfsr(lfsr(seed)));
                if (j < 4) pos_mv[j/2][j%2] <= seed[11:0];
                else neg_mv[j-4] <= seed[11:0];
            end
            settle;
        end
        // Both low with interrupts on, then switched off three ways
        pos_mv <= '0;
        neg_mv <= {2{12'hFFF}};
        for (int i = 0; i < 2; i++) begin
            cfg[i] = 4'h9;
            bus(1'b1, 5'(OFS_CFG0 + CFG_STRIDE * i), 8'h19);
        end
        rearm(1'b0);
        mask = 2'b11;
        bus(1'b1, OFS_MASK, 8'h03);
        settle;
        cfg[0] = 4'h8;
        bus(1'b1, OFS_CFG0, 8'h18);
        settle;
        apc5 = 1'b1;
        bus(1'b1, OFS_APC, 8'h20);
        settle;
        bus(1'b0, OFS_APC, 8'h00);
        chk_reg("aux_power_control", 8'h20, rd);
        apc5 = 1'b0;
        bus(1'b1, OFS_APC, 8'h00);
        rearm(1'b0);
        tpd <= 1'b1;
        settle;
        tpd <= 1'b0;
        rearm(1'b1);
        settle;
        // Write without byte lane zero is ignored
        be <= 4'hE;
        bus(1'b1, OFS_MASK, 8'h00);
        be <= 4'hF;
        bus(1'b0, OFS_MASK, 8'h00);
        chk_reg("mask", 8'h03, rd);
        // Frozen core sees no change until enable returns
        ce <= 1'b0;
        neg_mv <= '0;
        pos_mv <= {4{12'h001}};
        repeat (12) @(posedge clk);
        chk_pin("irq_frozen", 6'h00, {5'h00, irq});
        chk_pin("result_frozen", {4'h0, prev}, {4'h0, res_out});
        ce <= 1'b1;
        settle;
        stop_test;
    end
endmodule : tb
